// file: inc/ccp_pkg.sv
package ccp_pkg;
    // unit register indices on the link
    localparam int REG_ADDR_W = 3;
    localparam logic [2:0] IDX_CONTROL = 3'h0;
    localparam logic [2:0] IDX_VALUE_LOW = 3'h1;
    localparam logic [2:0] IDX_VALUE_HIGH = 3'h2;
    localparam logic [2:0] IDX_T1_LOW = 3'h3;
    localparam logic [2:0] IDX_T1_HIGH = 3'h4;
    localparam logic [2:0] IDX_PERIOD = 3'h5;
    localparam logic [2:0] IDX_T2_CONTROL = 3'h6;
    localparam logic [2:0] IDX_T2_COUNT = 3'h7;
    // control register fields
    localparam int MODE_LSB = 0;
    localparam int DUTY_LSB = 4;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TRIGGER = 4'hB;
    localparam logic [1:0] CLASS_COMPARE = 2'h2;
    localparam logic [1:0] CLASS_PWM = 2'h3;
    // timer2 control fields
    localparam int T2_RUN_BIT = 2;
    localparam int T2_PS_LSB = 0;
    localparam logic [1:0] PS_1 = 2'h0;
    localparam logic [1:0] PS_4 = 2'h1;
    localparam logic [5:0] FINE_TOP_1 = 6'h03;
    localparam logic [5:0] FINE_TOP_4 = 6'h0F;
    localparam logic [5:0] FINE_TOP_16 = 6'h3F;
    // reset values and the Timer1 top count
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] T1_MAX = 16'hFFFF;
    // controller register offsets (AHB byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REG_WRITE = 8'h08;
    localparam logic [7:0] ADDR_REG_READ = 8'h0C;
    localparam logic [7:0] ADDR_READ_DATA = 8'h10;
    localparam logic [7:0] ADDR_CONV_COUNT = 8'h14;
    localparam logic [7:0] ADDR_T1_DIV = 8'h18;
    // controller fields
    localparam int CTRL_ADC_EN = 0;
    localparam int CTRL_PIN_DIR = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int ST_EVENT = 0;
    localparam int ST_T1_OVF = 1;
    localparam int ST_T2_MATCH = 2;
    localparam int ST_PIN = 3;
    localparam int CMD_ADDR_LSB = 8;
endpackage

// file: inc/ccp_if.sv
`timescale 1ns/1ns
interface ccp_if;
    logic reg_wr;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic timer1_tick;
    logic adc_enable;
    logic adc_start;
    logic ccp_event;
    logic timer1_overflow;
    logic timer2_match;
    logic pin_out;
    logic pin_oe;

    modport unit (
        input reg_wr, reg_addr, reg_wdata, timer1_tick, adc_enable,
        output reg_rdata, adc_start, ccp_event, timer1_overflow, timer2_match,
        output pin_out, pin_oe
    );
    modport host (
        output reg_wr, reg_addr, reg_wdata, timer1_tick, adc_enable,
        input reg_rdata, adc_start, ccp_event, timer1_overflow, timer2_match,
        input pin_out, pin_oe
    );
endinterface

// file: hdl/ccp_unit.sv
`timescale 1ns/1ns
module ccp_unit (
    // system
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // high while the system clock is considered stopped
    input wire logic SLEEP,
    // link to the controller
    ccp_if.unit LINK
);
    logic [7:0] control;
    logic [7:0] value_low;
    logic [7:0] value_high;
    logic [7:0] period;
    logic [7:0] t2_control;
    logic [7:0] t2_count;
    logic [15:0] t1_count;
    logic [1:0] duty_latch;
    logic [5:0] fine;
    logic pin_level;
    logic match_prev;

    logic [3:0] mode;
    logic trig_mode;
    logic compare_mode;
    logic pwm_mode;
    logic awake;
    logic match;
    logic match_new;
    logic t1_write;
    logic t1_reset;
    logic [1:0] prescale;
    logic [5:0] fine_top;
    logic t2_run;
    logic fine_wrap;
    logic period_end;
    logic [9:0] duty_next;
    logic t2_write;
    logic [5:0] next_fine;
    logic [7:0] next_t2_count;
    logic [1:0] next_tb_low;
    logic [9:0] next_time_base;

    assign mode = control[ccp_pkg::MODE_LSB +: 4];
    assign trig_mode = (mode == ccp_pkg::MODE_TRIGGER);
    assign compare_mode = (mode[3:2] == ccp_pkg::CLASS_COMPARE);
    assign pwm_mode = (mode[3:2] == ccp_pkg::CLASS_PWM);
    assign awake = ~SLEEP;

    // register writes over the link
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            control <= ccp_pkg::CONTROL_RESET;
            value_low <= ccp_pkg::BYTE_RESET;
            period <= ccp_pkg::PERIOD_RESET;
            t2_control <= ccp_pkg::BYTE_RESET;
        end else if (LINK.reg_wr) begin
            unique case (LINK.reg_addr)
                ccp_pkg::IDX_CONTROL: begin
                    control <= LINK.reg_wdata;
                end
                ccp_pkg::IDX_VALUE_LOW: begin
                    value_low <= LINK.reg_wdata;
                end
                ccp_pkg::IDX_PERIOD: begin
                    period <= LINK.reg_wdata;
                end
                ccp_pkg::IDX_T2_CONTROL: begin
                    t2_control <= LINK.reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read-back mux
    always_comb begin
        unique case (LINK.reg_addr)
            ccp_pkg::IDX_CONTROL: LINK.reg_rdata = control;
            ccp_pkg::IDX_VALUE_LOW: LINK.reg_rdata = value_low;
            ccp_pkg::IDX_VALUE_HIGH: LINK.reg_rdata = value_high;
            ccp_pkg::IDX_T1_LOW: LINK.reg_rdata = t1_count[7:0];
            ccp_pkg::IDX_T1_HIGH: LINK.reg_rdata = t1_count[15:8];
            ccp_pkg::IDX_PERIOD: LINK.reg_rdata = period;
            ccp_pkg::IDX_T2_CONTROL: LINK.reg_rdata = t2_control;
            ccp_pkg::IDX_T2_COUNT: LINK.reg_rdata = t2_count;
        endcase
    end

    // ---------------- compare against Timer1 ----------------
    assign match = (t1_count == {value_high, value_low});
    // only the first cycle of a standing match counts as an event
    assign match_new = awake & compare_mode & match & ~match_prev;
    assign LINK.ccp_event = match_new;
    // one pulse per match in trigger mode, gated by the converter enable
    assign LINK.adc_start = match_new & trig_mode & LINK.adc_enable;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            match_prev <= 1'b0;
        end else if (awake) begin
            match_prev <= compare_mode & match;
        end
    end

    assign t1_write = LINK.reg_wr &
                      (LINK.reg_addr == ccp_pkg::IDX_T1_LOW ||
                       LINK.reg_addr == ccp_pkg::IDX_T1_HIGH);
    // reset waits for the Timer1 tick and needs the match still standing
    assign t1_reset = trig_mode & match;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            t1_count <= 16'h0000;
        end else if (t1_write) begin
            if (LINK.reg_addr == ccp_pkg::IDX_T1_LOW) begin
                t1_count[7:0] <= LINK.reg_wdata;
            end else begin
                t1_count[15:8] <= LINK.reg_wdata;
            end
        end else if (awake && LINK.timer1_tick) begin
            if (t1_reset) begin
                t1_count <= 16'h0000;
            end else begin
                t1_count <= t1_count + 16'h0001;
            end
        end
    end

    // only a genuine wrap reports overflow
    assign LINK.timer1_overflow = awake & LINK.timer1_tick & ~t1_write & ~t1_reset &
                                  (t1_count == ccp_pkg::T1_MAX);

    // ---------------- Timer2 time base ----------------
    assign prescale = t2_control[ccp_pkg::T2_PS_LSB +: 2];
    assign t2_run = t2_control[ccp_pkg::T2_RUN_BIT] & awake;

    always_comb begin
        if (prescale == ccp_pkg::PS_1) begin
            fine_top = ccp_pkg::FINE_TOP_1;
        end else if (prescale == ccp_pkg::PS_4) begin
            fine_top = ccp_pkg::FINE_TOP_4;
        end else begin
            fine_top = ccp_pkg::FINE_TOP_16;
        end
    end

    assign fine_wrap = t2_run & (fine == fine_top);
    assign period_end = fine_wrap & (t2_count == period);
    assign LINK.timer2_match = period_end;
    assign duty_next = {value_low, control[ccp_pkg::DUTY_LSB +: 2]};

    // prescaler restarts whenever software writes the count
    assign t2_write = LINK.reg_wr & (LINK.reg_addr == ccp_pkg::IDX_T2_COUNT);
    assign next_fine = (t2_write || fine_wrap) ? 6'h00 : (t2_run ? fine + 6'h01 : fine);

    always_comb begin
        if (t2_write) begin
            next_t2_count = LINK.reg_wdata;
        end else if (period_end) begin
            next_t2_count = ccp_pkg::BYTE_RESET;
        end else if (fine_wrap) begin
            next_t2_count = t2_count + 8'h01;
        end else begin
            next_t2_count = t2_count;
        end
    end

    always_comb begin
        if (prescale == ccp_pkg::PS_1) begin
            next_tb_low = next_fine[1:0];
        end else if (prescale == ccp_pkg::PS_4) begin
            next_tb_low = next_fine[3:2];
        end else begin
            next_tb_low = next_fine[5:4];
        end
    end

    // time base of the coming cycle, so the registered pin drops at the duty count
    assign next_time_base = {next_t2_count, next_tb_low};

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fine <= 6'h00;
            t2_count <= ccp_pkg::BYTE_RESET;
        end else begin
            fine <= next_fine;
            t2_count <= next_t2_count;
        end
    end

    // duty double buffer; software owns the high byte outside PWM
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            value_high <= ccp_pkg::BYTE_RESET;
            duty_latch <= 2'h0;
        end else if (pwm_mode) begin
            if (period_end) begin
                value_high <= value_low;
                duty_latch <= control[ccp_pkg::DUTY_LSB +: 2];
            end
        end else if (LINK.reg_wr && LINK.reg_addr == ccp_pkg::IDX_VALUE_HIGH) begin
            value_high <= LINK.reg_wdata;
        end
    end

    // high is the on state; a duty past the period never clears the pin
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_level <= 1'b0;
        end else if (!pwm_mode) begin
            pin_level <= 1'b0;
        end else if (period_end) begin
            pin_level <= (duty_next != 10'h000);
        end else if (t2_run && next_time_base == {value_high, duty_latch}) begin
            pin_level <= 1'b0;
        end
    end

    // pin is driven only in PWM mode, never in compare or trigger mode
    assign LINK.pin_oe = pwm_mode;
    assign LINK.pin_out = pin_level;
endmodule

// file: hdl/ccp_host.sv
`timescale 1ns/1ns
module ccp_host (
    // system
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    // output pad
    output logic CCP_PIN,
    output logic CCP_PIN_OE,
    // link to the unit
    ccp_if.host LINK
);
    logic [1:0] ctrl;
    logic [2:0] status;
    logic [7:0] read_data;
    logic [15:0] conv_count;
    logic [7:0] t1_div;
    logic [7:0] t1_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_pend;
    logic reg_wr;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic tick;
    logic addr_phase;
    logic data_wr;
    logic [2:0] st_set;
    logic [2:0] st_clr;
    logic pin_drive;
    logic [31:0] rd_mux;

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign addr_phase = HSEL & HTRANS[1] & HREADY;
    assign data_wr = wr_pend;

    // address phase capture; read data registered for the data phase
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA <= 32'h00000000;
        end else begin
            wr_pend <= addr_phase & HWRITE;
            wr_addr <= HADDR[7:0];
            if (addr_phase && !HWRITE) begin
                HRDATA <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (HADDR[7:0])
            ccp_pkg::ADDR_CTRL: rd_mux[1:0] = ctrl;
            ccp_pkg::ADDR_STATUS: rd_mux[3:0] = {CCP_PIN, status};
            ccp_pkg::ADDR_READ_DATA: rd_mux[7:0] = read_data;
            ccp_pkg::ADDR_CONV_COUNT: rd_mux[15:0] = conv_count;
            ccp_pkg::ADDR_T1_DIV: rd_mux[7:0] = t1_div;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl <= ccp_pkg::CTRL_RESET;
            t1_div <= 8'h00;
        end else if (data_wr && wr_addr == ccp_pkg::ADDR_CTRL) begin
            ctrl <= HWDATA[1:0];
        end else if (data_wr && wr_addr == ccp_pkg::ADDR_T1_DIV) begin
            t1_div <= HWDATA[7:0];
        end
    end

    // sticky events, write one to clear, a new event wins over the clear
    assign st_set = {LINK.timer2_match, LINK.timer1_overflow, LINK.ccp_event};
    assign st_clr = (data_wr && wr_addr == ccp_pkg::ADDR_STATUS) ? HWDATA[2:0] : 3'h0;
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            status <= 3'h0;
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end

    // register commands are relayed in the order software issues them
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            reg_wr <= 1'b0;
            rd_pend <= 1'b0;
            reg_addr <= 3'h0;
            reg_wdata <= 8'h00;
        end else begin
            reg_wr <= data_wr && wr_addr == ccp_pkg::ADDR_REG_WRITE;
            rd_pend <= data_wr && wr_addr == ccp_pkg::ADDR_REG_READ;
            if (data_wr && (wr_addr == ccp_pkg::ADDR_REG_WRITE ||
                            wr_addr == ccp_pkg::ADDR_REG_READ)) begin
                reg_addr <= HWDATA[ccp_pkg::CMD_ADDR_LSB +: 3];
                reg_wdata <= HWDATA[7:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            read_data <= 8'h00;
        end else if (rd_pend) begin
            read_data <= LINK.reg_rdata;
        end
    end

    // Timer1 clock: one tick every t1_div + 1 cycles
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            t1_cnt <= 8'h00;
            tick <= 1'b0;
        end else begin
            tick <= (t1_cnt == t1_div);
            t1_cnt <= (t1_cnt == t1_div) ? 8'h00 : t1_cnt + 8'h01;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            conv_count <= 16'h0000;
        end else if (LINK.adc_start) begin
            conv_count <= conv_count + 16'h0001;
        end
    end

    assign LINK.reg_wr = reg_wr;
    assign LINK.reg_addr = reg_addr;
    assign LINK.reg_wdata = reg_wdata;
    assign LINK.timer1_tick = tick;
    assign LINK.adc_enable = ctrl[ccp_pkg::CTRL_ADC_EN];

    // pad driven only with the direction bit cleared
    assign pin_drive = LINK.pin_oe & ~ctrl[ccp_pkg::CTRL_PIN_DIR];
    assign CCP_PIN_OE = pin_drive;
    assign CCP_PIN = pin_drive & LINK.pin_out;
endmodule

// file: hdl/ccp_unit_fix.sv
`timescale 1ns/1ns

// file: tb/ccp_trigger_and_pwm_assertions.sv
`timescale 1ns/1ns
module ccp_trigger_and_pwm_assertions (
    // system
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // link between the two ends
    input wire logic reg_wr,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic timer1_tick,
    input wire logic adc_enable,
    input wire logic adc_start,
    input wire logic ccp_event,
    input wire logic timer1_overflow,
    input wire logic timer2_match,
    input wire logic pin_out,
    input wire logic pin_oe
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    // pin leaves low for high
    sequence s_pin_rise;
        !pin_out ##1 pin_out;
    endsequence

    AST_EVENT_SINGLE: assert property (ccp_event |=> !ccp_event)
        else $error("compare event longer than one cycle");
    AST_START_SINGLE: assert property (adc_start |=> !adc_start)
        else $error("converter start longer than one cycle");
    AST_START_CAUSE: assert property (adc_start |-> adc_enable && ccp_event)
        else $error("converter start without enable or match");
    AST_TRIG_NO_OVF: assert property (adc_start |-> !timer1_overflow)
        else $error("trigger reset raised timer1 overflow");
    AST_OVF_CAUSE: assert property (timer1_overflow |-> timer1_tick ##1 !timer1_overflow)
        else $error("overflow without tick or too long");
    AST_OE_MODE: assert property ((reg_addr == ccp_pkg::IDX_CONTROL) |->
        (pin_oe == (reg_rdata[3:2] == ccp_pkg::CLASS_PWM)))
        else $error("pin enable does not follow control mode");
    AST_PIN_RISE_AT_WRAP: assert property (s_pin_rise |-> $past(timer2_match, 1))
        else $error("pin rose away from period end");
    AST_T2_SINGLE: assert property (timer2_match |=> !timer2_match)
        else $error("period match longer than one cycle");
endmodule

// file: tb/ccp_trigger_and_pwm_tb_top.sv
`timescale 1ns/1ns
module ccp_trigger_and_pwm_tb_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic sleep = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic ccp_pin;
    logic ccp_pin_oe;
    logic [31:0] rd;
    int bad_count = 0;
    int n_tests = 0;
    int starts = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int s0;
    int hi;
    int per;
    int mul;
    int expv;
    logic [7:0] vl_t [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h01};
    logic [1:0] dc_t [5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1};
    logic [1:0] ps_t [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1};

    ccp_if link ();
    ccp_unit u_ccp_unit (.SYS_CLK(sys_clk), .RSTN(rstn), .SLEEP(sleep), .LINK(link));
    ccp_host u_ccp_host (.SYS_CLK(sys_clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .CCP_PIN(ccp_pin),
        .CCP_PIN_OE(ccp_pin_oe), .LINK(link));
    ccp_trigger_and_pwm_assertions u_ccp_trigger_and_pwm_assertions (.SYS_CLK(sys_clk),
        .RSTN(rstn), .reg_wr(link.reg_wr), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .timer1_tick(link.timer1_tick), .adc_enable(link.adc_enable),
        .adc_start(link.adc_start), .ccp_event(link.ccp_event),
        .timer1_overflow(link.timer1_overflow), .timer2_match(link.timer2_match),
        .pin_out(link.pin_out), .pin_oe(link.pin_oe));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // converter starts and spacing between them
    always @(negedge sys_clk) begin
        cyc <= cyc + 1;
        if (link.adc_start === 1'b1) begin
            starts <= starts + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic uw(input logic [2:0] i, input logic [7:0] d);
        ahb(1'b1, ccp_pkg::ADDR_REG_WRITE, {21'h0, i, d});
    endtask

    task automatic ur(input logic [2:0] i);
        ahb(1'b1, ccp_pkg::ADDR_REG_READ, {21'h0, i, 8'h0});
        repeat (3) @(posedge sys_clk);
        ahb(1'b0, ccp_pkg::ADDR_READ_DATA, 32'h0);
    endtask

    task automatic wait_wrap;
        for (int i = 0; i < 300 && link.timer2_match !== 1'b1; i++) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        chk(32'h0, 32'h1);
        end_sim();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        ahb(1'b0, ccp_pkg::ADDR_CTRL, 32'h0);
        chk(rd, {30'h0, ccp_pkg::CTRL_RESET});
        chk({30'h0, hresp, hreadyout}, 32'h1);
        ur(ccp_pkg::IDX_PERIOD);
        chk(rd[7:0], ccp_pkg::PERIOD_RESET);
        ur(ccp_pkg::IDX_CONTROL);
        chk(rd[7:0], ccp_pkg::CONTROL_RESET);
        ahb(1'b1, 8'h1C, 32'hFFFFFFFF);
        ahb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        // trigger mode, compare value 0x10 (period 17 ticks), adc on, pin still an input
        ahb(1'b1, ccp_pkg::ADDR_T1_DIV, 32'hFF);
        uw(ccp_pkg::IDX_VALUE_LOW, 8'h10);
        uw(ccp_pkg::IDX_VALUE_HIGH, 8'h00);
        uw(ccp_pkg::IDX_CONTROL, {4'h0, ccp_pkg::MODE_TRIGGER});
        uw(ccp_pkg::IDX_T1_HIGH, 8'h00);
        uw(ccp_pkg::IDX_T1_LOW, 8'h00);
        ahb(1'b1, ccp_pkg::ADDR_CTRL, 32'h3);
        ahb(1'b1, ccp_pkg::ADDR_STATUS, 32'h7);
        ahb(1'b1, ccp_pkg::ADDR_T1_DIV, 32'h0);
        repeat (400) @(posedge sys_clk);
        chk(gap, 17);
        chk(link.pin_oe, 1'b0);
        ahb(1'b0, ccp_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'h1);
        sleep <= 1'b1;
        s0 = starts;
        repeat (100) @(posedge sys_clk);
        chk(starts, s0);
        sleep <= 1'b0;
        ahb(1'b1, ccp_pkg::ADDR_CTRL, 32'h2);
        s0 = starts;
        ahb(1'b0, ccp_pkg::ADDR_CONV_COUNT, 32'h0);
        chk(rd[15:0], starts[15:0]);
        repeat (60) @(posedge sys_clk);
        chk(starts, s0);
        // match at the top count must not count as overflow
        ahb(1'b1, ccp_pkg::ADDR_T1_DIV, 32'hFF);
        uw(ccp_pkg::IDX_VALUE_LOW, 8'hFF);
        uw(ccp_pkg::IDX_VALUE_HIGH, 8'hFF);
        uw(ccp_pkg::IDX_T1_HIGH, 8'hFF);
        uw(ccp_pkg::IDX_T1_LOW, 8'hF0);
        ahb(1'b1, ccp_pkg::ADDR_CTRL, 32'h3);
        ahb(1'b1, ccp_pkg::ADDR_STATUS, 32'h7);
        s0 = starts;
        ahb(1'b1, ccp_pkg::ADDR_T1_DIV, 32'h0);
        repeat (300) @(posedge sys_clk);
        chk(starts - s0, 1);
        ahb(1'b0, ccp_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1], 1'b0);
        // match removed before the slow tick: no reset
        ahb(1'b1, ccp_pkg::ADDR_T1_DIV, 32'hFF);
        uw(ccp_pkg::IDX_VALUE_LOW, 8'h05);
        uw(ccp_pkg::IDX_VALUE_HIGH, 8'h00);
        uw(ccp_pkg::IDX_T1_HIGH, 8'h00);
        uw(ccp_pkg::IDX_T1_LOW, 8'h04);
        for (int i = 0; i < 600 && link.ccp_event !== 1'b1; i++) @(negedge sys_clk);
        ur(ccp_pkg::IDX_T1_LOW);
        chk(rd[7:0], 8'h05);
        uw(ccp_pkg::IDX_VALUE_LOW, 8'h20);
        repeat (300) @(posedge sys_clk);
        ur(ccp_pkg::IDX_T1_LOW);
        chk(rd[7:0], 8'h06);
        // software-interrupt compare: a genuine wrap sets overflow, no start
        uw(ccp_pkg::IDX_CONTROL, 8'h0A);
        uw(ccp_pkg::IDX_T1_HIGH, 8'hFF);
        uw(ccp_pkg::IDX_T1_LOW, 8'hF0);
        ahb(1'b1, ccp_pkg::ADDR_STATUS, 32'h7);
        s0 = starts;
        ahb(1'b1, ccp_pkg::ADDR_T1_DIV, 32'h0);
        repeat (400) @(posedge sys_clk);
        ahb(1'b0, ccp_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'h3);
        chk(starts, s0);
        chk(link.pin_oe, 1'b0);
        $display("trigger test done");
        // pwm, period register 3, duty table
        ahb(1'b1, ccp_pkg::ADDR_CTRL, 32'h2);
        uw(ccp_pkg::IDX_PERIOD, 8'h03);
        for (int k = 0; k < 5; k++) begin
            uw(ccp_pkg::IDX_CONTROL, {2'h0, dc_t[k], 4'hC});
            uw(ccp_pkg::IDX_VALUE_LOW, vl_t[k]);
            ahb(1'b1, ccp_pkg::ADDR_STATUS, 32'h4);
            uw(ccp_pkg::IDX_T2_CONTROL, {5'h0, 1'b1, ps_t[k]});
            rd = 32'h0;
            for (int i = 0; i < 60 && rd[2] !== 1'b1; i++) ahb(1'b0, ccp_pkg::ADDR_STATUS, 0);
            chk(rd[2], 1'b1);
            chk(ccp_pin_oe, 1'b0);
            ahb(1'b1, ccp_pkg::ADDR_CTRL, 32'h0);
            wait_wrap();
            wait_wrap();
            mul = (ps_t[k] == ccp_pkg::PS_4) ? 4 : 1;
            per = 4 * (3 + 1) * mul;
            expv = {vl_t[k], dc_t[k]} * mul;
            expv = (expv > per) ? per : expv;
            hi = 0;
            repeat (per) begin
                @(negedge sys_clk);
                hi += (ccp_pin === 1'b1) ? 1 : 0;
            end
            chk(hi, expv);
            chk(ccp_pin_oe, 1'b1);
            ur(ccp_pkg::IDX_VALUE_HIGH);
            chk(rd[7:0], vl_t[k]);
            ahb(1'b1, ccp_pkg::ADDR_CTRL, 32'h2);
        end
        ahb(1'b1, ccp_pkg::ADDR_CTRL, 32'h0);
        uw(ccp_pkg::IDX_CONTROL, 8'h00);
        repeat (3) @(posedge sys_clk);
        chk({ccp_pin_oe, ccp_pin}, 2'h0);
        $display("pwm test done");
        end_sim();
    end
endmodule
